// >>> inc/ssm_pkg.sv
// Constants, types and register map of the synchronous modem controller.
package ssm_pkg;
    localparam logic [7:0]  OFF_CTRL      = 8'h00;
    localparam logic [7:0]  OFF_STATUS    = 8'h04;
    localparam logic [7:0]  OFF_MASK      = 8'h08;
    localparam logic [7:0]  OFF_RXDATA    = 8'h0C;
    localparam logic [7:0]  OFF_TXDATA    = 8'h10;
    localparam int unsigned CTRL_SYN_LSB  = 0;
    localparam int unsigned CTRL_MODE_LSB = 8;
    localparam int unsigned CTRL_RXEN_BIT = 10;
    localparam int unsigned CTRL_TXEN_BIT = 11;
    localparam int unsigned ST_RX_READY   = 0;
    localparam int unsigned ST_TX_REQ     = 1;
    localparam int unsigned ST_RX_TERR    = 2;
    localparam int unsigned ST_TX_TERR    = 3;
    localparam int unsigned RX_PAR_BIT    = 15;
    localparam int unsigned RX_FULL_BIT   = 16;
    localparam int unsigned TX_FULL_BIT   = 8;
    localparam logic [11:0] CTRL_RST      = 12'h032;
    localparam logic [3:0]  MASK_RST      = 4'h0;
    localparam logic [7:0]  SYN_FORBIDDEN = 8'hFF;
    localparam logic [3:0]  CHAR_BITS     = 4'h8;
    localparam logic [3:0]  LAST_BIT      = 4'h7;

    typedef enum logic [1:0] {
        SSM_SYN_TWO,
        SSM_SYN_ONE,
        SSM_SYN_NONE
    } ssm_sync_mode_e;

    typedef enum logic [1:0] {
        SSM_HUNT,
        SSM_SECOND,
        SSM_LOCKED
    } ssm_rx_state_e;

    typedef struct packed {
        ssm_rx_state_e state;
        logic [7:0]    shreg;
        logic [3:0]    cnt;
        logic          par;
    } ssm_rx_s;

    typedef struct packed {
        logic [7:0] shreg;
        logic [3:0] left;
        logic       active;
        logic       dout;
    } ssm_tx_s;
endpackage : ssm_pkg

// >>> logic/ssm_sync_modem_ctrl.sv
// Synchronous modem controller: serial link, double buffers, APB registers, interrupt.
//
// Behaviour
// - Shift received bits in on receive clock.
// - Full character moves to receive buffer.
// - Buffer load raises input service request.
// - Unread buffer at next character: input timing error.
// - Host read delivers character, frees buffer.
// - Parity bit on bus line 15, odd=1.
// - Basic mode needs two SYN before data.
// - SYN code strappable, all ones excluded.
// - Option: lock after a single SYN.
// - Option: lock on first space bit.
// - Space lock holds until block ends.
// - Host low byte held in transmit buffer.
// - Buffer moves to shifter, sent on clock.
// - Buffer transfer raises output service request.
// - Empty buffer at character end: output timing error.
`timescale 1ns/100ps
module ssm_sync_modem_ctrl
    import ssm_pkg::*;
(
    // Clock, reset and clock enable.
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        ce,
    // APB slave.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Data set link.
    input  wire logic        rx_clk_pin,
    input  wire logic        rx_data_pin,
    input  wire logic        tx_clk_pin,
    output logic             tx_data_pin,
    // Interrupt.
    output logic             irq
);
    logic [2:0]     rxc_q, rxd_q, txc_q;
    ssm_rx_s        rx_q, rx_d;
    ssm_tx_s        tx_q, tx_d;
    logic [7:0]     rxbuf_q, rxbuf_d, txbuf_q, txbuf_d;
    logic           rxpar_q, rxpar_d, rx_full_q, rx_full_d, tx_full_q, tx_full_d;
    logic [11:0]    ctrl_q, ctrl_d;
    logic [3:0]     st_q, st_d, mask_q, mask_d, ev;
    logic [31:0]    prdata_d;
    logic           pready_d, pslverr_d, irq_d;
    logic           rx_rise, tx_fall, rx_bit, rx_done, tx_load, tx_under;
    logic           acc, setup, wr, rd_rx, rx_en, tx_en, syn_ok, mapped;
    logic [7:0]     syn, sh;
    ssm_sync_mode_e mode;

    // Only stage 1 of each pin feeds stage 2; stage 2 and 3 of the clock pins drive logic, and only stage 2 of the data pin.
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            rxc_q <= 3'h0;
            rxd_q <= 3'h0;
            txc_q <= 3'h0;
        end
        else if (ce)
        begin
            rxc_q <= {rxc_q[1:0], rx_clk_pin};
            rxd_q <= {rxd_q[1:0], rx_data_pin};
            txc_q <= {txc_q[1:0], tx_clk_pin};
        end
    end

    assign rx_rise = rxc_q[1] & ~rxc_q[2];
    assign tx_fall = ~txc_q[1] & txc_q[2];
    assign rx_bit  = rxd_q[1];
    assign syn     = ctrl_q[CTRL_SYN_LSB +: 8];
    assign mode    = ssm_sync_mode_e'(ctrl_q[CTRL_MODE_LSB +: 2]);
    assign rx_en   = ctrl_q[CTRL_RXEN_BIT];
    assign tx_en   = ctrl_q[CTRL_TXEN_BIT];
    assign syn_ok  = (syn != SYN_FORBIDDEN);
    assign sh      = {rx_bit, rx_q.shreg[7:1]};
    assign setup   = psel & ~penable;
    assign acc     = psel & penable & pready;
    assign wr      = acc & pwrite;
    assign rd_rx   = acc & ~pwrite & (paddr == OFF_RXDATA);
    assign mapped  = (paddr == OFF_CTRL) | (paddr == OFF_STATUS) | (paddr == OFF_MASK)
                   | (paddr == OFF_RXDATA) | (paddr == OFF_TXDATA);

    // Receive side: hunt, lock and character assembly.
    always_comb
    begin
        rx_d      = rx_q;
        rxbuf_d   = rxbuf_q;
        rxpar_d   = rxpar_q;
        rx_full_d = rx_full_q;
        rx_done   = 1'b0;
        if (rd_rx)
            rx_full_d = 1'b0;
        if (!rx_en)
        begin
            // Clearing the enable ends the block and restarts the hunt.
            rx_d.state = SSM_HUNT;
            rx_d.cnt   = 4'h0;
            rx_d.par   = 1'b0;
        end
        else if (rx_rise)
        begin
            rx_d.shreg = sh;
            unique case (rx_q.state)
                SSM_HUNT:
                begin
                    if (rx_q.cnt != CHAR_BITS)
                        rx_d.cnt = rx_q.cnt + 4'h1;
                    if (mode == SSM_SYN_NONE)
                    begin
                        if (!rx_bit)
                        begin
                            rx_d.state = SSM_LOCKED;
                            rx_d.cnt   = 4'h1;
                            rx_d.par   = 1'b0;
                        end
                    end
                    // Mode code 3 never locks, which parks the receiver.
                    else if (mode inside {SSM_SYN_TWO, SSM_SYN_ONE} && syn_ok
                             && rx_q.cnt >= LAST_BIT && sh == syn)
                    begin
                        rx_d.cnt   = 4'h0;
                        rx_d.par   = 1'b0;
                        rx_d.state = (mode == SSM_SYN_ONE) ? SSM_LOCKED : SSM_SECOND;
                    end
                end
                SSM_SECOND:
                begin
                    rx_d.cnt = rx_q.cnt + 4'h1;
                    if (rx_q.cnt == LAST_BIT)
                    begin
                        rx_d.cnt   = 4'h0;
                        rx_d.state = (sh == syn) ? SSM_LOCKED : SSM_HUNT;
                    end
                end
                SSM_LOCKED:
                begin
                    rx_d.par = rx_q.par ^ rx_bit;
                    rx_d.cnt = rx_q.cnt + 4'h1;
                    if (rx_q.cnt == LAST_BIT)
                    begin
                        rx_done   = 1'b1;
                        rxbuf_d   = sh;
                        rxpar_d   = rx_q.par ^ rx_bit;
                        rx_full_d = 1'b1;
                        rx_d.cnt  = 4'h0;
                        rx_d.par  = 1'b0;
                    end
                end
                default:
                begin
                    rx_d.state = SSM_HUNT;
                    rx_d.cnt   = 4'h0;
                end
            endcase
        end
    end

    // Transmit side: buffer to shifter hand-over and underrun.
    always_comb
    begin
        tx_d      = tx_q;
        txbuf_d   = txbuf_q;
        tx_full_d = tx_full_q;
        tx_load   = 1'b0;
        tx_under  = 1'b0;
        if (!tx_en)
        begin
            tx_d.active = 1'b0;
            tx_d.left   = 4'h0;
            tx_d.dout   = 1'b1;
        end
        else if (tx_fall)
        begin
            if (tx_q.left == 4'h0)
            begin
                if (tx_full_q)
                begin
                    tx_load     = 1'b1;
                    tx_d.shreg  = {1'b1, txbuf_q[7:1]};
                    tx_d.dout   = txbuf_q[0];
                    tx_d.left   = LAST_BIT;
                    tx_d.active = 1'b1;
                    tx_full_d   = 1'b0;
                end
                else
                begin
                    tx_under    = tx_q.active;
                    tx_d.active = 1'b0;
                    tx_d.dout   = 1'b1;
                end
            end
            else
            begin
                tx_d.dout  = tx_q.shreg[0];
                tx_d.shreg = {1'b1, tx_q.shreg[7:1]};
                tx_d.left  = tx_q.left - 4'h1;
            end
        end
        // A host write in the hand-over cycle still fills the buffer.
        if (wr && paddr == OFF_TXDATA)
        begin
            txbuf_d   = pwdata[7:0];
            tx_full_d = 1'b1;
        end
    end

    // Registers, events and APB answer.
    always_comb
    begin
        ev              = 4'h0;
        ev[ST_RX_READY] = rx_done;
        ev[ST_RX_TERR]  = rx_done & rx_full_q & ~rd_rx;
        ev[ST_TX_REQ]   = tx_load;
        ev[ST_TX_TERR]  = tx_under;
        ctrl_d          = ctrl_q;
        mask_d          = mask_q;
        st_d            = st_q;
        if (wr && paddr == OFF_CTRL)
            ctrl_d = pwdata[11:0];
        if (wr && paddr == OFF_MASK)
            mask_d = pwdata[3:0];
        if (wr && paddr == OFF_STATUS)
            st_d = st_q & ~pwdata[3:0];
        st_d      = st_d | ev;
        irq_d     = |(st_d & mask_d);
        pready_d  = setup;
        pslverr_d = setup & ~mapped;
        prdata_d  = 32'h0000_0000;
        if (setup && !pwrite)
        begin
            unique case (paddr)
                OFF_CTRL:   prdata_d[11:0] = ctrl_q;
                OFF_STATUS: prdata_d[3:0]  = st_q;
                OFF_MASK:   prdata_d[3:0]  = mask_q;
                OFF_RXDATA:
                begin
                    prdata_d[7:0]        = rxbuf_q;
                    prdata_d[RX_PAR_BIT]  = rxpar_q;
                    prdata_d[RX_FULL_BIT] = rx_full_q;
                end
                OFF_TXDATA: prdata_d[TX_FULL_BIT] = tx_full_q;
                default:    prdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            rx_q      <= '{SSM_HUNT, 8'h00, 4'h0, 1'b0};
            tx_q      <= '{8'hFF, 4'h0, 1'b0, 1'b1};
            rxbuf_q   <= 8'h00;
            txbuf_q   <= 8'h00;
            rxpar_q   <= 1'b0;
            rx_full_q <= 1'b0;
            tx_full_q <= 1'b0;
            ctrl_q    <= CTRL_RST;
            mask_q    <= MASK_RST;
            st_q      <= 4'h0;
            prdata    <= 32'h0000_0000;
            pready    <= 1'b0;
            pslverr   <= 1'b0;
            irq       <= 1'b0;
        end
        else if (ce)
        begin
            rx_q      <= rx_d;
            tx_q      <= tx_d;
            rxbuf_q   <= rxbuf_d;
            txbuf_q   <= txbuf_d;
            rxpar_q   <= rxpar_d;
            rx_full_q <= rx_full_d;
            tx_full_q <= tx_full_d;
            ctrl_q    <= ctrl_d;
            mask_q    <= mask_d;
            st_q      <= st_d;
            prdata    <= prdata_d;
            pready    <= pready_d;
            pslverr   <= pslverr_d;
            irq       <= irq_d;
        end
    end

    assign tx_data_pin = tx_q.dout;

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    chk_rx_buffer_load: assert property (ce && rx_done |=> rx_full_q && st_q[ST_RX_READY])
        else $error("Completed character not buffered or not flagged.");
    chk_rx_overrun_flag: assert property (ce && rx_done && rx_full_q && !rd_rx |=> st_q[ST_RX_TERR])
        else $error("Overrun did not raise input timing error.");
    chk_rx_read_frees: assert property (ce && rd_rx && !rx_done |=> !rx_full_q)
        else $error("Host read did not free receive buffer.");
    chk_rx_parity_odd: assert property (ce && rx_done |=> rxpar_q == ^rxbuf_q)
        else $error("Parity bit disagrees with buffered character.");
    chk_tx_load_req: assert property (ce && tx_load |=> tx_q.active && st_q[ST_TX_REQ]
        && tx_q.left == 4'h7)
        else $error("Transmit hand-over not reflected in state.");
    chk_tx_underrun_flag: assert property (ce && tx_en && tx_fall && tx_q.active
        && tx_q.left == 4'h0 && !tx_full_q |=> st_q[ST_TX_TERR] && tx_data_pin)
        else $error("Underrun did not raise output timing error.");
    chk_err_sticky: assert property (ce && st_q[ST_RX_TERR] && !(wr && paddr == OFF_STATUS)
        |=> st_q[ST_RX_TERR])
        else $error("Input timing error cleared without service.");
    chk_freeze_state: assert property (!ce |=> $stable(rx_q) && $stable(tx_q)
        && $stable(st_q))
        else $error("State changed while clock enable was low.");
    chk_space_lock: assert property (ce && rx_en && rx_rise && mode == SSM_SYN_NONE
        && rx_q.state == SSM_HUNT && !rx_bit |=> rx_q.state == SSM_LOCKED)
        else $error("First space bit did not lock alignment.");
    chk_irq_level: assert property (irq == |(st_q & mask_q))
        else $error("Interrupt output disagrees with masked status.");
    chk_rx_lock_hold: assert property (ce && rx_en && rx_q.state == SSM_LOCKED
        |=> rx_q.state == SSM_LOCKED)
        else $error("Receiver left alignment while still enabled.");
    chk_syn_ones_refused: assert property (ce && rx_en && !syn_ok
        && mode != SSM_SYN_NONE && rx_q.state == SSM_HUNT |=> rx_q.state == SSM_HUNT)
        else $error("All-ones code was accepted as a sync character.");
    chk_two_syn_miss: assert property (ce && rx_en && rx_rise && rx_q.state == SSM_SECOND
        && rx_q.cnt == LAST_BIT && sh != syn |=> rx_q.state == SSM_HUNT)
        else $error("Second sync mismatch did not restart the hunt.");
    // The bus answers with no wait state and ready stands for one cycle only.
    chk_apb_ready_next: assert property (ce && setup |=> pready)
        else $error("Setup phase not answered in the next cycle.");
    chk_apb_ready_pulse: assert property (ce && pready |=> !pready)
        else $error("Ready stood longer than one cycle.");
    chk_tx_idle_mark: assert property (ce && !tx_en |=> tx_data_pin)
        else $error("Transmit line not at mark while disabled.");

    cov_rx_char: cover property (ce && rx_done);
    cov_two_syn_lock: cover property (rx_q.state == SSM_SECOND ##[1:200]
        rx_q.state == SSM_LOCKED);
    cov_tx_underrun: cover property (ce && tx_under);
    cov_rx_overrun: cover property (ce && ev[ST_RX_TERR]);
endmodule : ssm_sync_modem_ctrl

// >>> testbench/ssm_dataset_model.sv
// Behavioural synchronous data set: link clocks, receive data and transmit capture.
`timescale 1ns/100ps
module ssm_dataset_model
(
    // Link pins.
    output logic      rx_clk_pin,
    output logic      rx_data_pin,
    output logic      tx_clk_pin,
    input  wire logic tx_data_pin
);
    initial
    begin
        rx_clk_pin  = 1'b0;
        rx_data_pin = 1'b1;
        tx_clk_pin  = 1'b1;
    end

    // The clock stands still outside frames and the data line then shows the inverse bit.
    // Pins move 2 ns after a system clock edge, never on it, and each call lasts a whole
    // number of system clock periods so that the next call keeps the same offset.
    task automatic send_byte(input logic [7:0] b);
        #2;
        for (int i = 0; i < 8; i++)
        begin
            rx_data_pin = b[i];
            #40 rx_clk_pin = 1'b1;
            #40 rx_clk_pin = 1'b0;
        end
        rx_data_pin = ~b[7];
        #6;
    endtask : send_byte

    task automatic tx_run(input int n, output logic [15:0] got);
        got = 16'h0000;
        #2;
        for (int i = 0; i < n; i++)
        begin
            tx_clk_pin = 1'b0;
            #40 got[i] = tx_data_pin;
            tx_clk_pin = 1'b1;
            #40;
        end
        #6;
    endtask : tx_run
endmodule : ssm_dataset_model

// >>> testbench/tb.sv
// Self-checking bench: registers, receive framing modes, interrupt and transmit.
`timescale 1ns/100ps
module tb
    import ssm_pkg::*;
;
    logic        clock;
    logic        rst;
    logic        ce;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        rx_clk_pin;
    logic        rx_data_pin;
    logic        tx_clk_pin;
    logic        tx_data_pin;
    logic        irq;
    logic [31:0] rd;
    logic        err;
    logic [15:0] got;
    int          mismatches = 0;
    int          cmp_count = 0;
    int          cycles = 0;

    ssm_sync_modem_ctrl ssm_sync_modem_ctrl_i (.clock(clock), .rst(rst), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_clk_pin(rx_clk_pin),
        .rx_data_pin(rx_data_pin), .tx_clk_pin(tx_clk_pin), .tx_data_pin(tx_data_pin),
        .irq(irq));

    ssm_dataset_model ssm_dataset_model_i (.rx_clk_pin(rx_clk_pin),
        .rx_data_pin(rx_data_pin), .tx_clk_pin(tx_clk_pin), .tx_data_pin(tx_data_pin));

    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    task automatic end_sim();
        $display("compares=%0d mismatches=%0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : end_sim

    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            end_sim();
        end
    end

    task automatic check(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e)
        begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : check

    // The request is held until pready is seen high at a rising edge.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clock);
        penable <= 1'b1;
        do
        begin
            @(posedge clock);
        end
        while (pready !== 1'b1);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        check(rd, e);
    endtask : rchk

    task automatic wait_irq();
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 200)
        begin
            @(posedge clock);
            n++;
        end
        check({31'h0, irq}, 32'h0000_0001);
    endtask : wait_irq

    // Clearing the enable first drops any lock before the new mode applies.
    task automatic cfg(input logic [31:0] c);
        wr(OFF_CTRL, 32'h0000_0000);
        wr(OFF_CTRL, c);
        wr(OFF_STATUS, 32'h0000_000F);
    endtask : cfg

    initial
    begin
        rst     = 1'b1;
        ce      = 1'b1;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0000_0000;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        rchk(OFF_CTRL, 32'h0000_0032);
        rchk(OFF_STATUS, 32'h0000_0000);
        rchk(OFF_MASK, 32'h0000_0000);
        rchk(8'h40, 32'h0000_0000);
        check({31'h0, err}, 32'h0000_0001);
        wr(OFF_MASK, 32'h0000_0001);
        cfg(32'h0000_0416);
        ssm_dataset_model_i.send_byte(8'h16);
        ssm_dataset_model_i.send_byte(8'h5A);
        repeat (8) @(posedge clock);
        rchk(OFF_STATUS, 32'h0000_0000);
        cfg(32'h0000_0716);
        ssm_dataset_model_i.send_byte(8'h16);
        ssm_dataset_model_i.send_byte(8'h16);
        ssm_dataset_model_i.send_byte(8'hA5);
        repeat (8) @(posedge clock);
        rchk(OFF_STATUS, 32'h0000_0000);
        cfg(32'h0000_04FF);
        ssm_dataset_model_i.send_byte(8'hFF);
        ssm_dataset_model_i.send_byte(8'hFF);
        ssm_dataset_model_i.send_byte(8'h5A);
        repeat (8) @(posedge clock);
        rchk(OFF_STATUS, 32'h0000_0000);
        cfg(32'h0000_0416);
        ssm_dataset_model_i.send_byte(8'h16);
        ssm_dataset_model_i.send_byte(8'h16);
        ssm_dataset_model_i.send_byte(8'hA5);
        wait_irq();
        rchk(OFF_RXDATA, 32'h0001_00A5);
        apb(1'b0, OFF_RXDATA, 32'h0000_0000);
        check({31'h0, rd[RX_FULL_BIT]}, 32'h0000_0000);
        ssm_dataset_model_i.send_byte(8'h07);
        ssm_dataset_model_i.send_byte(8'h83);
        repeat (8) @(posedge clock);
        rchk(OFF_STATUS, 32'h0000_0005);
        rchk(OFF_RXDATA, 32'h0001_8083);
        cfg(32'h0000_0516);
        ssm_dataset_model_i.send_byte(8'h16);
        ssm_dataset_model_i.send_byte(8'h5A);
        wait_irq();
        rchk(OFF_RXDATA, 32'h0001_005A);
        cfg(32'h0000_0632);
        ssm_dataset_model_i.send_byte(8'h5A);
        wait_irq();
        rchk(OFF_RXDATA, 32'h0001_005A);
        // A character sent while the clock enable is low must leave no trace.
        ce <= 1'b0;
        ssm_dataset_model_i.send_byte(8'h33);
        @(posedge clock);
        ce <= 1'b1;
        rchk(OFF_STATUS, 32'h0000_0001);
        rchk(OFF_RXDATA, 32'h0000_005A);
        wr(OFF_MASK, 32'h0000_0000);
        repeat (2) @(posedge clock);
        check({31'h0, irq}, 32'h0000_0000);
        wr(OFF_MASK, 32'h0000_0001);
        wait_irq();
        wr(OFF_STATUS, 32'h0000_0001);
        repeat (2) @(posedge clock);
        check({31'h0, irq}, 32'h0000_0000);
        cfg(32'h0000_0832);
        wr(OFF_TXDATA, 32'h0000_003C);
        rchk(OFF_TXDATA, 32'h0000_0100);
        rchk(OFF_STATUS, 32'h0000_0000);
        ssm_dataset_model_i.tx_run(9, got);
        check({16'h0000, got}, 32'h0000_013C);
        rchk(OFF_STATUS, 32'h0000_000A);
        end_sim();
    end
endmodule : tb
